// ===== hw/svd_cfg.svh
// Contract
// - software picks one of sixteen trip levels via four-bit limit field, low nibble
// - limit field all ones selects the external trip input instead of divider tap
// - voltage reaching selected trip point sets the detect flag
// - direction one detects rising, zero detects falling
// - detector powered only while the enable bit is set
// - interrupt raised only when detect enable and global enable are both set
// - no detector interrupt until reference-stable status is set after enabling; code still raises irq from a flag left set before the enable
// - start-up interval timed by reference circuit, not by clock cycle count
// - detect flag cannot set before start-up interval ends; crossings may be missed
// - enabled detector runs in sleep; crossing sets flag and wakes device
// - after detector wake, resume at interrupt vector if global enable set; code also requires detect enable
// - any reset returns registers to reset values, detector disabled
// - reference-stable status bit is read-only, writes ignored
`ifndef SVD_CFG_SVH
`define SVD_CFG_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define SVD_ADDR_W       12
`define SVD_CTRL_OFS     12'h000
`define SVD_FLAG_OFS     12'h004
`define SVD_MASK_OFS     12'h008
`define SVD_GLOB_OFS     12'h00c

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define SVD_LIMIT_W      4
`define SVD_LIMIT_EXT    4'hf
`define SVD_EN_BIT       4
`define SVD_STABLE_BIT   5
`define SVD_DIR_BIT      7
`define SVD_FLAG_BIT     2
`define SVD_GIE_BIT      7
`define SVD_LIMIT_RST    4'h0
`define SVD_DIR_RST      1'b0

`endif

// ===== hw/svd_pkg.sv
package svd_pkg;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b001,
    ST_WAIT  = 3'b010,
    ST_ARMED = 3'b100
  } det_state_t;

endpackage

// ===== hw/svd_event_qualify.sv
`include "svd_cfg.svh"

module svd_event_qualify (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic armed,
  input  wire logic direction_select,
  input  wire logic cmp_at_or_above,
  input  wire logic cmp_at_or_below,
  output logic      trip_event
);

  logic next_trip_event;

  // ----------------------------------------
  // direction-qualified crossing
  // ----------------------------------------
  // level sensitive: the flag is sticky, so a held condition simply keeps setting it
  always_comb begin
    next_trip_event = 1'b0;
    if (armed) begin
      if (direction_select) begin
        next_trip_event = cmp_at_or_above;
      end else begin
        next_trip_event = cmp_at_or_below;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_event <= 1'b0;
    end else begin
      trip_event <= next_trip_event;
    end
  end

endmodule

// ===== hw/supply_threshold_detector.sv
// Decided for this implementation: the APB slave port and the register offsets.
`include "svd_cfg.svh"

module supply_threshold_detector (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`SVD_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   reference_ready,
  input  wire logic                   cmp_at_or_above,
  input  wire logic                   cmp_at_or_below,
  input  wire logic                   sleep_mode,
  output logic                        detector_power,
  output logic      [3:0]             trip_limit_select,
  output logic                        external_trip_input_sel,
  output logic                        irq,
  output logic                        wake,
  output logic                        wake_to_vector
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  svd_pkg::det_state_t state;
  svd_pkg::det_state_t next_state;

  logic        direction_select;
  logic        detector_enable;
  logic        detect_flag;
  logic        detect_int_enable;
  logic        global_int_enable;
  logic        trip_event;
  logic        reference_stable;

  logic [3:0]  next_trip_limit_select;
  logic        next_direction_select;
  logic        next_detector_enable;
  logic        next_detect_flag;
  logic        next_detect_int_enable;
  logic        next_global_int_enable;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_irq;
  logic        next_wake;
  logic        next_wake_to_vector;
  logic        next_external_trip_input_sel;

  logic        wr_fire;
  logic        mapped;
  logic [31:0] read_word;

  assign reference_stable = (state == svd_pkg::ST_ARMED);
  assign detector_power   = detector_enable;
  assign wr_fire          = psel & penable & pready & pwrite;
  assign mapped           = (paddr == `SVD_CTRL_OFS) || (paddr == `SVD_FLAG_OFS) ||
                            (paddr == `SVD_MASK_OFS) || (paddr == `SVD_GLOB_OFS);

  // ----------------------------------------
  // start-up sequencing
  // ----------------------------------------
  // the wait is ended by the analog reference itself, so no cycle count is kept
  always_comb begin
    next_state = state;
    case (state)
      svd_pkg::ST_OFF: begin
        if (detector_enable) begin
          next_state = svd_pkg::ST_WAIT;
        end
      end
      svd_pkg::ST_WAIT: begin
        if (!detector_enable) begin
          next_state = svd_pkg::ST_OFF;
        end else if (reference_ready) begin
          next_state = svd_pkg::ST_ARMED;
        end
      end
      svd_pkg::ST_ARMED: begin
        if (!detector_enable) begin
          next_state = svd_pkg::ST_OFF;
        end
      end
      default: begin
        next_state = svd_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= svd_pkg::ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  svd_event_qualify u_qualify (
    .pclk             (pclk),
    .presetn          (presetn),
    .armed            (reference_stable),
    .direction_select (direction_select),
    .cmp_at_or_above  (cmp_at_or_above),
    .cmp_at_or_below  (cmp_at_or_below),
    .trip_event       (trip_event)
  );

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always_comb begin
    next_trip_limit_select = trip_limit_select;
    next_direction_select  = direction_select;
    next_detector_enable   = detector_enable;
    next_detect_int_enable = detect_int_enable;
    next_global_int_enable = global_int_enable;
    next_detect_flag       = detect_flag;
    if (wr_fire) begin
      case (paddr)
        `SVD_CTRL_OFS: begin
          // stable bit is not taken from pwdata
          next_trip_limit_select = pwdata[`SVD_LIMIT_W-1:0];
          next_direction_select  = pwdata[`SVD_DIR_BIT];
          next_detector_enable   = pwdata[`SVD_EN_BIT];
        end
        `SVD_FLAG_OFS: begin
          if (pwdata[`SVD_FLAG_BIT]) begin
            next_detect_flag = 1'b0;
          end
        end
        `SVD_MASK_OFS: begin
          next_detect_int_enable = pwdata[`SVD_FLAG_BIT];
        end
        `SVD_GLOB_OFS: begin
          next_global_int_enable = pwdata[`SVD_GIE_BIT];
        end
        default: begin
          next_detect_flag = detect_flag;
        end
      endcase
    end
    // a crossing in the clearing cycle is kept: set wins
    if (trip_event) begin
      next_detect_flag = 1'b1;
    end
    next_external_trip_input_sel = (next_trip_limit_select == `SVD_LIMIT_EXT);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_limit_select       <= `SVD_LIMIT_RST;
      direction_select        <= `SVD_DIR_RST;
      detector_enable         <= 1'b0;
      detect_flag             <= 1'b0;
      detect_int_enable       <= 1'b0;
      global_int_enable       <= 1'b0;
      external_trip_input_sel <= 1'b0;
    end else begin
      trip_limit_select       <= next_trip_limit_select;
      direction_select        <= next_direction_select;
      detector_enable         <= next_detector_enable;
      detect_flag             <= next_detect_flag;
      detect_int_enable       <= next_detect_int_enable;
      global_int_enable       <= next_global_int_enable;
      external_trip_input_sel <= next_external_trip_input_sel;
    end
  end

  // ----------------------------------------
  // apb slave: one wait state, registered answer
  // ----------------------------------------
  always_comb begin
    read_word = 32'h0000_0000;
    case (paddr)
      `SVD_CTRL_OFS: begin
        read_word[`SVD_LIMIT_W-1:0] = trip_limit_select;
        read_word[`SVD_EN_BIT]      = detector_enable;
        read_word[`SVD_STABLE_BIT]  = reference_stable;
        read_word[`SVD_DIR_BIT]     = direction_select;
      end
      `SVD_FLAG_OFS: begin
        read_word[`SVD_FLAG_BIT] = detect_flag;
      end
      `SVD_MASK_OFS: begin
        read_word[`SVD_FLAG_BIT] = detect_int_enable;
      end
      `SVD_GLOB_OFS: begin
        read_word[`SVD_GIE_BIT] = global_int_enable;
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
    next_pready  = psel & penable & ~pready;
    next_pslverr = psel & penable & ~pready & ~mapped;
    next_prdata  = prdata;
    if (psel && penable && !pready && !pwrite) begin
      next_prdata = read_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------
  // interrupt and wake
  // ----------------------------------------
  // flag only rises once armed, but a flag left set from before a disable still raises irq during the stable wait
  always_comb begin
    next_irq            = detect_flag & detect_int_enable & global_int_enable;
    next_wake           = sleep_mode & detect_flag & detector_enable;
    next_wake_to_vector = next_wake & detect_int_enable & global_int_enable;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq            <= 1'b0;
      wake           <= 1'b0;
      wake_to_vector <= 1'b0;
    end else begin
      irq            <= next_irq;
      wake           <= next_wake;
      wake_to_vector <= next_wake_to_vector;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_enable_rise;
    $rose(detector_enable);
  endsequence

  sequence s_ref_ready_wait;
    (!reference_stable && detector_enable && !reference_ready);
  endsequence

  a_limit_write: assert property (
    wr_fire && paddr == `SVD_CTRL_OFS |=> trip_limit_select == $past(pwdata[3:0]))
    else $error("limit field not stored");

  a_ext_select: assert property (
    external_trip_input_sel == (trip_limit_select == 4'hf))
    else $error("external input select wrong");

  a_flag_cause: assert property (
    $rose(detect_flag) |-> $past(trip_event))
    else $error("flag set without crossing");

  a_event_dir: assert property (
    reference_stable && direction_select && cmp_at_or_above && !$rose(reference_stable)
      |=> trip_event)
    else $error("rising crossing not seen");

  a_power_off: assert property (
    !detector_enable |-> !detector_power ##1 state != svd_pkg::ST_ARMED)
    else $error("detector on while disabled");

  a_irq_gate: assert property (
    irq |-> $past(detect_int_enable) && $past(global_int_enable) && $past(detect_flag))
    else $error("irq without both enables");

  a_stable_wait: assert property (
    s_enable_rise ##0 s_ref_ready_wait[*2] |-> !irq || $past(detect_flag, 2))
    else $error("irq before stable");

  a_flag_armed: assert property (
    trip_event |-> $past(reference_stable))
    else $error("crossing qualified before start-up");

  a_sleep_wake: assert property (
    sleep_mode && detect_flag && detector_enable |=> wake)
    else $error("no wake in sleep");

  a_wake_vector: assert property (
    wake_to_vector |-> wake && $past(global_int_enable))
    else $error("vector wake without global enable");

  a_stable_ro: assert property (
    wr_fire && paddr == `SVD_CTRL_OFS && !pwdata[`SVD_EN_BIT] |-> ##2 !reference_stable)
    else $error("stable status written");

  a_disable_clear: assert property (
    $fell(detector_enable) |=> state == svd_pkg::ST_OFF ##1 !reference_stable [*2])
    else $error("stable kept after disable");

endmodule

// ===== sim/test_supply_threshold_detector.sv
`include "svd_cfg.svh"

module test_supply_threshold_detector;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    logic [7:0] w;
    logic [7:0] r;
    logic [3:0] lim;
    logic       ext;
    logic       pw;
  } row_t;

  logic        pclk            = 1'b0;
  logic        presetn         = 1'b0;
  logic        psel            = 1'b0;
  logic        penable         = 1'b0;
  logic        pwrite          = 1'b0;
  logic [11:0] paddr           = 12'h000;
  logic [31:0] pwdata          = 32'h0;
  logic        reference_ready = 1'b0;
  logic        cmp_at_or_above = 1'b0;
  logic        cmp_at_or_below = 1'b0;
  logic        sleep_mode      = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        detector_power;
  logic [3:0]  trip_limit_select;
  logic        external_trip_input_sel;
  logic        irq;
  logic        wake;
  logic        wake_to_vector;
  logic [31:0] q;
  logic        e;
  int          failures  = 0;
  int          tests_run = 0;

  // stable bit never reads 1 here: reference_ready stays low during the rows
  row_t rows [5] = '{'{8'h00, 8'h00, 4'h0, 1'b0, 1'b0}, '{8'h8e, 8'h8e, 4'he, 1'b0, 1'b0},
                     '{8'h0f, 8'h0f, 4'hf, 1'b1, 1'b0}, '{8'hff, 8'h9f, 4'hf, 1'b1, 1'b1},
                     '{8'h3a, 8'h1a, 4'ha, 1'b0, 1'b1}};

  supply_threshold_detector supply_threshold_detector_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reference_ready(reference_ready), .cmp_at_or_above(cmp_at_or_above),
    .cmp_at_or_below(cmp_at_or_below), .sleep_mode(sleep_mode), .detector_power(detector_power),
    .trip_limit_select(trip_limit_select), .external_trip_input_sel(external_trip_input_sel),
    .irq(irq), .wake(wake), .wake_to_vector(wake_to_vector)
  );

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here: a missing answer is ended by the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, q, exp);
  endtask

  task automatic bit_is(input string name, input logic seen, input logic exp);
    check(name, {31'h0, seen}, {31'h0, exp});
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    conclude();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    bit_is("detector_power", detector_power, 1'b0);
    for (int a = 0; a < 16; a += 4) rdchk("reset value", a[11:0], 32'h0);
    foreach (rows[i]) begin
      wr(`SVD_CTRL_OFS, {24'h0, rows[i].w});
      rdchk("control", `SVD_CTRL_OFS, {24'h0, rows[i].r});
      bit_is("pslverr", e, 1'b0);
      check("trip_limit_select", {28'h0, trip_limit_select}, {28'h0, rows[i].lim});
      bit_is("external_trip_input_sel", external_trip_input_sel, rows[i].ext);
      bit_is("detector_power", detector_power, rows[i].pw);
    end
    for (int l = 0; l < 16; l++) begin
      wr(`SVD_CTRL_OFS, {28'h0, l[3:0]});
      @(posedge pclk);
      check("trip_limit_select", {28'h0, trip_limit_select}, {28'h0, l[3:0]});
      bit_is("external_trip_input_sel", external_trip_input_sel, l[3:0] == `SVD_LIMIT_EXT);
    end
    // unmapped word: refused, reads zero
    apb(1'b1, 12'h010, 32'hff);
    bit_is("pslverr", e, 1'b1);
    rdchk("unmapped", 12'h010, 32'h0);
    bit_is("pslverr", e, 1'b1);
    // crossings during start-up are lost, however long it takes
    wr(`SVD_MASK_OFS, 32'h4);
    wr(`SVD_GLOB_OFS, 32'h80);
    wr(`SVD_CTRL_OFS, 32'h93);
    @(posedge pclk);
    cmp_at_or_above <= 1'b1;
    repeat (40) @(posedge pclk);
    rdchk("control", `SVD_CTRL_OFS, 32'h93);
    rdchk("flag", `SVD_FLAG_OFS, 32'h0);
    bit_is("irq", irq, 1'b0);
    cmp_at_or_above <= 1'b0;
    cmp_at_or_below <= 1'b1;
    reference_ready <= 1'b1;
    repeat (8) @(posedge pclk);
    rdchk("control", `SVD_CTRL_OFS, 32'hb3);
    rdchk("flag", `SVD_FLAG_OFS, 32'h0);
    cmp_at_or_above <= 1'b1;
    cmp_at_or_below <= 1'b0;
    repeat (2) @(posedge pclk);
    cmp_at_or_above <= 1'b0;
    repeat (4) @(posedge pclk);
    rdchk("flag", `SVD_FLAG_OFS, 32'h4);
    bit_is("irq", irq, 1'b1);
    wr(`SVD_GLOB_OFS, 32'h0);
    repeat (2) @(posedge pclk);
    bit_is("irq", irq, 1'b0);
    wr(`SVD_MASK_OFS, 32'h0);
    wr(`SVD_GLOB_OFS, 32'h80);
    repeat (2) @(posedge pclk);
    bit_is("irq", irq, 1'b0);
    wr(`SVD_FLAG_OFS, 32'h4);
    rdchk("flag", `SVD_FLAG_OFS, 32'h0);
    // falling detection while asleep
    wr(`SVD_CTRL_OFS, 32'h13);
    @(posedge pclk);
    sleep_mode      <= 1'b1;
    cmp_at_or_below <= 1'b1;
    repeat (4) @(posedge pclk);
    bit_is("wake", wake, 1'b1);
    bit_is("wake_to_vector", wake_to_vector, 1'b0);
    wr(`SVD_MASK_OFS, 32'h4);
    repeat (2) @(posedge pclk);
    bit_is("wake_to_vector", wake_to_vector, 1'b1);
    sleep_mode      <= 1'b0;
    cmp_at_or_below <= 1'b0;
    rdchk("flag", `SVD_FLAG_OFS, 32'h4);
    bit_is("wake", wake, 1'b0);
    wr(`SVD_FLAG_OFS, 32'h4);
    // disable drops the stable status; re-enable waits again
    reference_ready <= 1'b0;
    wr(`SVD_CTRL_OFS, 32'h03);
    rdchk("control", `SVD_CTRL_OFS, 32'h03);
    bit_is("detector_power", detector_power, 1'b0);
    wr(`SVD_CTRL_OFS, 32'h13);
    @(posedge pclk);
    cmp_at_or_below <= 1'b1;
    repeat (20) @(posedge pclk);
    rdchk("control", `SVD_CTRL_OFS, 32'h13);
    rdchk("flag", `SVD_FLAG_OFS, 32'h0);
    bit_is("irq", irq, 1'b0);
    // reset in mid-run
    presetn <= 1'b0;
    @(posedge pclk);
    presetn         <= 1'b1;
    cmp_at_or_below <= 1'b0;
    @(posedge pclk);
    bit_is("detector_power", detector_power, 1'b0);
    rdchk("control", `SVD_CTRL_OFS, 32'h0);
    rdchk("mask", `SVD_MASK_OFS, 32'h0);
    conclude();
  end

endmodule
